//--- verilog/iscd_top.v
// isolated switch command decoder: frame decode, status reply, switch control
// Notes on behaviour
// - decode every frame, act on command only if address equals strap pins
// - 0001 opens at once, 0010 opens at next current zero crossing
// - 0011 closes at once, 0100 closes at next voltage polarity change
// - 0101 closes at once plus dither, 0110 closes at crossing plus dither
// - 1111 polls leaving switch alone; 0111 selects heartbeat reporting
// - 0000 and 1000 to 1110 are no-operations
// - command applied only after all three status bits shifted out
// - zero-crossing close waits for first voltage sign change after shift-out
// - zero-crossing open waits for current inside turn-off window after shift-out
// - dither with low system voltage opens switch for off period, each retry
// - non-latched poll to our address restarts watchdog, state unchanged
// - reported status is the state before the current command
// - status zero mirrors first two pulses, status one mirrors all pulses
// - status 001 open, 100 closed, 101 closed dithering, 111 overcurrent
// - watchdog pin strapped high holds switch state indefinitely
// - non-latched: watchdog expiry opens switch; command before expiry restarts it
// - watchdog restarted only by frames addressed to this device
// - long low is reset; zero is two pulses, one is four
// - frame is reset, preamble 110, address, command, three status slots
// - heartbeat while open: one pulse-width pulse per supply zero crossing
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "iscd_map.vh"
module iscd_top #(
    parameter [15:0] RESET_CYC = `ISCD_RESET_CYC,  // control-line reset time
    parameter [15:0] HB_CYC = `ISCD_HB_CYC,        // heartbeat pulse width
    parameter [15:0] DOFF_CYC = `ISCD_DOFF_CYC,    // dither off period
    parameter [19:0] DRTY_CYC = `ISCD_DRTY_CYC     // dither retry interval
) (
    input wire pclk,              // system clock, 250 MHz
    input wire presetn,           // async reset, active low
    input wire psel,              // apb select
    input wire penable,           // apb access phase
    input wire pwrite,            // apb write
    input wire [11:0] paddr,      // apb byte address
    input wire [31:0] pwdata,     // apb write data
    output wire pready,           // apb ready, always high
    output reg [31:0] prdata,     // apb read data
    output reg pslverr,           // apb error on unmapped address
    input wire ctrl_line,         // pulse-coded control line pin
    input wire addr_strap_bit2,   // address strap pin
    input wire addr_strap_bit1,   // address strap pin
    input wire addr_strap_bit0,   // address strap pin
    input wire watchdog_pin,      // high: latched operation
    input wire wd_expired,        // watchdog comparator tripped
    input wire sys_volt_low,      // system voltage below dither threshold
    input wire vsw_sign,          // sign of voltage across switch
    input wire i_in_window,       // load current inside turn-off window
    input wire overcurrent,       // filtered overcurrent comparator
    output reg data_out,          // return line level
    output reg data_oe_n,         // return line enable, low drives
    output wire switch_drive,     // gate command for the power switch
    output reg wd_recharge        // one cycle: restart watchdog
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RECV = 3'b010;
    localparam [2:0] ST_SLOT = 3'b100;
    // ==========================================================
    // status bit for a slot: most significant bit first
    function stat_bit;
        input [2:0] code;
        input [3:0] idx;
        begin
            case (idx)
                4'ha: stat_bit = code[2];
                4'hb: stat_bit = code[1];
                default: stat_bit = code[0];
            endcase
        end
    endfunction
    wire line_s, frame_reset, bit_done, bit_val;
    wire [2:0] pulse_cnt;
    iscd_pulse_rx #(
        .RESET_CYC(RESET_CYC)
    ) u_rx (
        .pclk(pclk),
        .presetn(presetn),
        .line_raw(ctrl_line),
        .line_s(line_s),
        .frame_reset(frame_reset),
        .bit_done(bit_done),
        .bit_val(bit_val),
        .pulse_cnt(pulse_cnt)
    );
    // ==========================================================
    // synchronise straps and comparator outputs
    reg [8:0] in_m, in_s;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_m <= 9'h000;
            in_s <= 9'h000;
        end else begin
            in_m <= {overcurrent, i_in_window, vsw_sign, sys_volt_low, wd_expired,
                     watchdog_pin, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            in_s <= in_m;
        end
    end
    wire [2:0] strap_addr = in_s[2:0];
    wire latched_mode = in_s[3];
    wire wd_exp_s = in_s[4];
    wire sys_low_s = in_s[5];
    wire vsign_s = in_s[6];
    wire iwin_s = in_s[7];
    wire oc_s = in_s[8];
    reg vsign_d, oc_d;
    wire vsign_edge = vsign_s ^ vsign_d;
    wire oc_rise = oc_s & ~oc_d;
    // ==========================================================
    // frame state and switch state
    reg [2:0] state, last_addr, snap;
    reg [3:0] bit_cnt, last_cmd;
    reg [9:0] shreg;
    reg last_match, cmd_ok, sw_closed, dither_en, oc_flag, hb_mode, pend_close, pend_open;
    reg decode_en;
    reg [15:0] hb_cnt, doff_cnt;
    reg [19:0] drty_cnt;
    reg [7:0] frame_cnt;
    // reply code from current state; overcurrent wins
    wire [2:0] cur_status = oc_flag ? `ISCD_ST_OVERCUR :
                            !sw_closed ? `ISCD_ST_OPEN :
                            dither_en ? `ISCD_ST_CLOSED_DI : `ISCD_ST_CLOSED;
    wire [9:0] next_shreg = {shreg[8:0], bit_val};
    wire frame_end = (state == ST_SLOT) && bit_done && (bit_cnt == `ISCD_SLOT_LAST);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 10'h000;
            last_addr <= 3'h0;
            last_cmd <= 4'h0;
            last_match <= 1'b0;
            cmd_ok <= 1'b0;
            snap <= `ISCD_ST_OPEN;
            frame_cnt <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    bit_cnt <= 4'h0;
                end
                ST_RECV: begin
                    if (bit_done) begin
                        shreg <= next_shreg;
                        bit_cnt <= bit_cnt + 4'h1;
                        // command field complete: capture and freeze reply
                        if (bit_cnt == `ISCD_CMD_LAST_BIT) begin
                            last_addr <= next_shreg[6:4];
                            last_cmd <= next_shreg[3:0];
                            last_match <= (next_shreg[6:4] == strap_addr);
                            cmd_ok <= (next_shreg[9:7] == `ISCD_PREAMBLE) &&
                                      (next_shreg[6:4] == strap_addr);
                            snap <= cur_status;
                            frame_cnt <= frame_cnt + 8'h01;
                            state <= ST_SLOT;
                        end
                    end
                end
                ST_SLOT: begin
                    if (bit_done) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `ISCD_SLOT_LAST) begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // a reset on the line always aborts the frame; reception restarts only while decode_en is set
            if (frame_reset) begin
                state <= decode_en ? ST_RECV : ST_IDLE;
                bit_cnt <= 4'h0;
                cmd_ok <= 1'b0;
            end
        end
    end
    // ==========================================================
    // switch control: commands apply only at frame end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_closed <= 1'b0;
            dither_en <= 1'b0;
            oc_flag <= 1'b0;
            hb_mode <= 1'b0;
            pend_close <= 1'b0;
            pend_open <= 1'b0;
            wd_recharge <= 1'b0;
            vsign_d <= 1'b0;
            oc_d <= 1'b0;
        end else begin
            vsign_d <= vsign_s;
            oc_d <= oc_s;
            wd_recharge <= 1'b0;
            // pending crossings are checked only after the frame ended
            if (pend_close && vsign_edge) begin
                sw_closed <= 1'b1;
                pend_close <= 1'b0;
            end
            if (pend_open && iwin_s) begin
                sw_closed <= 1'b0;
                pend_open <= 1'b0;
            end
            if (frame_end && cmd_ok) begin
                wd_recharge <= 1'b1;
                case (last_cmd)
                    `ISCD_CMD_OFF_IMM: begin
                        sw_closed <= 1'b0;
                        dither_en <= 1'b0;
                        pend_close <= 1'b0;
                        pend_open <= 1'b0;
                    end
                    `ISCD_CMD_OFF_ZC: begin
                        dither_en <= 1'b0;
                        pend_close <= 1'b0;
                        pend_open <= 1'b1;
                    end
                    `ISCD_CMD_ON_IMM, `ISCD_CMD_ON_IMM_DI: begin
                        sw_closed <= 1'b1;
                        oc_flag <= 1'b0;
                        hb_mode <= 1'b0;
                        dither_en <= (last_cmd == `ISCD_CMD_ON_IMM_DI);
                        pend_close <= 1'b0;
                        pend_open <= 1'b0;
                    end
                    `ISCD_CMD_ON_ZC, `ISCD_CMD_ON_ZC_DI: begin
                        oc_flag <= 1'b0;
                        hb_mode <= 1'b0;
                        dither_en <= (last_cmd == `ISCD_CMD_ON_ZC_DI);
                        pend_close <= 1'b1;
                        pend_open <= 1'b0;
                    end
                    `ISCD_CMD_HEARTBEAT: begin
                        hb_mode <= 1'b1;
                    end
                    default: begin
                        // poll and forbidden codes leave the switch alone
                        hb_mode <= hb_mode;
                    end
                endcase
            end
            // watchdog expiry opens only in non-latched strapping
            if (!latched_mode && wd_exp_s) begin
                sw_closed <= 1'b0;
                pend_close <= 1'b0;
            end
            // overcurrent latches off until an on command
            if (oc_rise) begin
                oc_flag <= 1'b1;
                sw_closed <= 1'b0;
                pend_close <= 1'b0;
            end
        end
    end
    // ==========================================================
    // dither: every retry interval, a low supply opens for off period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drty_cnt <= 20'h00000;
            doff_cnt <= 16'h0000;
        end else if (!(dither_en && sw_closed)) begin
            drty_cnt <= 20'h00000;
            doff_cnt <= 16'h0000;
        end else begin
            if (doff_cnt != 16'h0000) begin
                doff_cnt <= doff_cnt - 16'h0001;
            end
            if (drty_cnt == DRTY_CYC - 20'h00001) begin
                drty_cnt <= 20'h00000;
                if (sys_low_s) begin
                    doff_cnt <= DOFF_CYC;
                end
            end else begin
                drty_cnt <= drty_cnt + 20'h00001;
            end
        end
    end
    assign switch_drive = sw_closed & (doff_cnt == 16'h0000);
    // ==========================================================
    // return line: status mirror in slots; a zero stops after pulse two, whose
    // second half is told from pulse three's first by the reply already high
    wire slot_bit = stat_bit(snap, bit_cnt);
    wire in_slot = (state == ST_SLOT) && cmd_ok;
    wire mirror = line_s && (slot_bit || pulse_cnt < 3'h2 ||
                             (pulse_cnt == 3'h2 && data_out));
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hb_cnt <= 16'h0000;
            data_out <= 1'b0;
            data_oe_n <= 1'b1;
        end else begin
            if (hb_cnt != 16'h0000) begin
                hb_cnt <= hb_cnt - 16'h0001;
            end else if (hb_mode && !sw_closed && vsign_edge) begin
                hb_cnt <= HB_CYC;
            end
            // frame reply beats heartbeat: only one may own the line
            if (in_slot) begin
                data_oe_n <= 1'b0;
                data_out <= mirror;
            end else if (hb_mode && !sw_closed) begin
                data_oe_n <= 1'b0;
                data_out <= (hb_cnt != 16'h0000);
            end else begin
                data_oe_n <= 1'b1;
                data_out <= 1'b0;
            end
        end
    end
    // ==========================================================
    // apb slave: zero wait states, error on unmapped address
    wire apb_acc = psel && penable;
    wire hit_ctrl = (paddr == `ISCD_REG_CTRL);
    wire hit_state = (paddr == `ISCD_REG_STATE);
    wire hit_last = (paddr == `ISCD_REG_LASTCMD);
    assign pready = 1'b1;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decode_en <= `ISCD_CTRL_RESET;
        end else if (apb_acc && pwrite && hit_ctrl) begin
            decode_en <= pwdata[0];
        end
    end
    always @* begin
        prdata = 32'h00000000;
        pslverr = psel && !(hit_ctrl || hit_state || hit_last);
        if (psel && !pwrite) begin
            if (hit_ctrl) begin
                prdata = {31'h00000000, decode_en};
            end else if (hit_state) begin
                prdata = {20'h00000, pend_open, pend_close, latched_mode, hb_mode,
                          oc_flag, dither_en, switch_drive, sw_closed, 1'b0, cur_status};
            end else if (hit_last) begin
                prdata = {16'h0000, frame_cnt, last_match, last_addr, last_cmd};
            end
        end
    end
endmodule

//--- verilog/iscd_map.vh
// constants for the isolated switch command decoder
`ifndef ISCD_MAP_VH
`define ISCD_MAP_VH

// ==========================================================
// clock and link timing
`define ISCD_CLK_PS 4000
`define ISCD_RESET_NS 25000
`define ISCD_RESET_CYC ((`ISCD_RESET_NS * 1000 + `ISCD_CLK_PS - 1) / `ISCD_CLK_PS)
`define ISCD_GAP_NS 1500
`define ISCD_GAP_CYC ((`ISCD_GAP_NS * 1000) / `ISCD_CLK_PS)
`define ISCD_HB_NS 20000
`define ISCD_HB_CYC ((`ISCD_HB_NS * 1000) / `ISCD_CLK_PS)
`define ISCD_DOFF_NS 25000
`define ISCD_DOFF_CYC ((`ISCD_DOFF_NS * 1000) / `ISCD_CLK_PS)
`define ISCD_DRTY_US 4000
// two-step scaling: microseconds times a million would overflow 32 bits
`define ISCD_DRTY_CYC ((`ISCD_DRTY_US * 1000) / (`ISCD_CLK_PS / 1000))

// ==========================================================
// frame layout
`define ISCD_PREAMBLE 3'h6
`define ISCD_CMD_LAST_BIT 4'h9
`define ISCD_SLOT_FIRST 4'ha
`define ISCD_SLOT_LAST 4'hc

// ==========================================================
// command codes
`define ISCD_CMD_OFF_IMM 4'h1
`define ISCD_CMD_OFF_ZC 4'h2
`define ISCD_CMD_ON_IMM 4'h3
`define ISCD_CMD_ON_ZC 4'h4
`define ISCD_CMD_ON_IMM_DI 4'h5
`define ISCD_CMD_ON_ZC_DI 4'h6
`define ISCD_CMD_HEARTBEAT 4'h7
`define ISCD_CMD_POLL 4'hf

// ==========================================================
// status codes
`define ISCD_ST_OPEN 3'h1
`define ISCD_ST_CLOSED 3'h4
`define ISCD_ST_CLOSED_DI 3'h5
`define ISCD_ST_OVERCUR 3'h7

// ==========================================================
// register map (byte addresses) and reset values
`define ISCD_REG_CTRL 12'h000
`define ISCD_REG_STATE 12'h004
`define ISCD_REG_LASTCMD 12'h008
`define ISCD_CTRL_RESET 1'h1

`endif

//--- verilog/iscd_pulse_rx.v
// control line receiver: sync, reset detect and pulse-count bit decode
`timescale 1ns/1ps
`include "iscd_map.vh"

module iscd_pulse_rx #(
    parameter [15:0] RESET_CYC = `ISCD_RESET_CYC
) (
    input wire pclk,            // system clock
    input wire presetn,         // async reset, active low
    input wire line_raw,        // control line pin
    output reg line_s,          // synchronised line level
    output reg frame_reset,     // one cycle: low longer than reset time
    output reg bit_done,        // one cycle: a bit has ended
    output reg bit_val,         // value of the bit just ended
    output reg [2:0] pulse_cnt  // pulses seen so far in current bit
);

    localparam [15:0] GAP_CYC = `ISCD_GAP_CYC;

    reg line_m;
    reg line_d;
    reg [15:0] low_cnt;

    // ==========================================================
    // two-stage synchroniser, then one more stage for edge detect
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_m <= 1'b0;
            line_s <= 1'b0;
            line_d <= 1'b0;
        end else begin
            line_m <= line_raw;
            line_s <= line_m;
            line_d <= line_s;
        end
    end

    // ==========================================================
    // low time gives both bit end (short gap) and reset (long low)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= 16'h0000;
            pulse_cnt <= 3'h0;
            bit_done <= 1'b0;
            bit_val <= 1'b0;
            frame_reset <= 1'b0;
        end else begin
            bit_done <= 1'b0;
            frame_reset <= 1'b0;
            if (line_s) begin
                low_cnt <= 16'h0000;
            end else if (low_cnt != RESET_CYC) begin
                low_cnt <= low_cnt + 16'h0001;
            end
            // saturate: a stuck line should not wrap the count
            if (line_s && !line_d && pulse_cnt != 3'h7) begin
                pulse_cnt <= pulse_cnt + 3'h1;
            end
            // two pulses mean zero, four mean one; three rounds up
            if (!line_s && low_cnt == GAP_CYC && pulse_cnt != 3'h0) begin
                bit_done <= 1'b1;
                bit_val <= (pulse_cnt >= 3'h3);
                pulse_cnt <= 3'h0;
            end
            if (!line_s && low_cnt == RESET_CYC - 16'h0001) begin
                frame_reset <= 1'b1;
            end
        end
    end

endmodule

//--- sim/iscd_top_checker.sv
// assertion checker bound to the decoder top
`timescale 1ns/1ps
module iscd_chk (
    input wire pclk,         // clock
    input wire presetn,      // reset, low
    input wire psel,         // apb select
    input wire [11:0] paddr, // apb address
    input wire pready,       // apb ready
    input wire pslverr,      // apb error
    input wire watchdog_pin, // latched strap
    input wire wd_expired,   // watchdog trip
    input wire overcurrent,  // overcurrent
    input wire data_out,     // return line
    input wire data_oe_n,    // return enable
    input wire switch_drive, // switch gate
    input wire wd_recharge   // restart pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // watchdog restart: single pulse, only just after the reply slots
    property p_rech; wd_recharge |=> !wd_recharge; endproperty
    a_rech: assert property (p_rech) else $error("recharge too long");
    property p_after;
        wd_recharge |-> !$past(data_oe_n) || !$past(data_oe_n, 2) || !$past(data_oe_n, 3);
    endproperty
    a_after: assert property (p_after) else $error("applied before reply");
    // protective opens, allowing for the input synchronisers
    property p_wd; (!watchdog_pin && wd_expired)[*6] |-> !switch_drive; endproperty
    a_wd: assert property (p_wd) else $error("expired but closed");
    property p_oc; $rose(overcurrent) |-> ##[1:6] !switch_drive; endproperty
    a_oc: assert property (p_oc) else $error("overcurrent but closed");
    // return line only toggles while driven
    property p_out; data_out |-> !data_oe_n; endproperty
    a_out: assert property (p_out) else $error("reply while released");
    // bus answer and reset state
    property p_err;
        psel |-> pslverr == !(paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008);
    endproperty
    a_err: assert property (p_err) else $error("bad error flag");
    property p_rdy; pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low");
    property p_rst; $rose(presetn) |-> data_oe_n && !switch_drive && !wd_recharge; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    c_rech: cover property (wd_recharge);
    c_close: cover property ($rose(switch_drive));
    c_reply: cover property (!data_oe_n && data_out);
endmodule
bind iscd_top iscd_chk CHK (.pclk, .presetn, .psel, .paddr, .pready, .pslverr, .watchdog_pin,
    .wd_expired, .overcurrent, .data_out, .data_oe_n, .switch_drive, .wd_recharge);

//--- sim/iscd_host.sv
// host model: sends pulse-coded frames, decodes the status reply
`timescale 1ns/1ps
module iscd_host (
    input wire pclk,      // clock
    input wire data_out,  // return line
    input wire data_oe_n, // return enable
    output reg ctrl_line  // control line
);
    reg [2:0] status = 3'h0;
    reg last = 1'b0;
    integer edges = 0;
    // released line reads low through its coupling cap; own return path
    always @(posedge pclk) begin
        last <= data_out & ~data_oe_n;
        if ((data_out & ~data_oe_n) && !last)
            edges <= edges + 1;
    end
    initial ctrl_line = 1'b0;
    // one frame; gap of 380 low cycles ends each bit, still short of a reset
    task automatic frame(input [2:0] a, input [3:0] c);
        reg [12:0] w;
        integer k, p, e0;
        begin
            w = {3'b110, a, c, 3'b111};
            ctrl_line <= 1'b0;
            repeat (420) @(posedge pclk);
            for (k = 12; k >= 0; k = k - 1) begin
                e0 = edges;
                for (p = 0; p < (w[k] ? 4 : 2); p = p + 1) begin
                    ctrl_line <= 1'b1;
                    repeat (2) @(posedge pclk);
                    ctrl_line <= 1'b0;
                    repeat (2) @(posedge pclk);
                end
                repeat (380) @(posedge pclk);
                if (k < 3)
                    status[k] = (edges - e0) >= 3;
            end
        end
    endtask
endmodule

//--- sim/iscd_top_tb.sv
// testbench for the isolated switch command decoder
`timescale 1ns/1ps
module iscd_top_tb;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0, q;
    reg wdp = 1'b1, wde = 1'b0, svl = 1'b0, vsw = 1'b0, iwin = 1'b0, oc = 1'b0, e;
    reg [7:0] seed = 8'd38;
    reg [2:0] strap = 3'h0;
    wire pready, pslverr, ctrl_line, data_out, data_oe_n, switch_drive, wd_recharge;
    wire [31:0] prdata;
    integer err_total = 0, check_count = 0, rch = 0, n_lo, n_hi, i;
    iscd_top #(.RESET_CYC(16'd400), .HB_CYC(16'd20), .DOFF_CYC(16'd20), .DRTY_CYC(20'd200))
        DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .ctrl_line(ctrl_line), .addr_strap_bit2(strap[2]),
        .addr_strap_bit1(strap[1]), .addr_strap_bit0(strap[0]), .watchdog_pin(wdp),
        .wd_expired(wde), .sys_volt_low(svl), .vsw_sign(vsw), .i_in_window(iwin),
        .overcurrent(oc), .data_out(data_out), .data_oe_n(data_oe_n),
        .switch_drive(switch_drive), .wd_recharge(wd_recharge));
    iscd_host HOST (.pclk(pclk), .data_out(data_out), .data_oe_n(data_oe_n),
        .ctrl_line(ctrl_line));
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected reply code from switch, dither and fault state
    function [2:0] est(input cl, input di, input f);
        est = f ? 3'h7 : (!cl ? 3'h1 : (di ? 3'h5 : 3'h4));
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            if (err_total == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // apb transfer; holds the request until pready is sampled high or 64 wait cycles pass
    task apb(input wr, input [11:0] a, input [31:0] d);
        integer t;
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && t < 64) begin
                t = t + 1;
                @(posedge pclk);
            end
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // frame, then reply code and switch state
    task cmd(input [2:0] a, input [3:0] c, input [2:0] s, input sw);
        begin
            HOST.frame(a, c);
            repeat (6) @(posedge pclk);
            chk({29'h0, HOST.status}, {29'h0, s});
            chk({31'h0, switch_drive}, {31'h0, sw});
        end
    endtask
    // count open-switch and high-return cycles over one retry interval
    task watch;
        begin
            n_lo = 0;
            n_hi = 0;
            for (i = 0; i < 200; i = i + 1) begin
                @(posedge pclk);
                n_lo = n_lo + (switch_drive === 1'b0);
                n_hi = n_hi + (data_out === 1'b1);
            end
        end
    endtask
    // supply is ac, so crossings are real
    task zc;
        begin
            vsw <= ~vsw;
            repeat (8) @(posedge pclk);
        end
    endtask
    initial forever #2 pclk = ~pclk;
    always @(posedge pclk)
        if (wd_recharge === 1'b1)
            rch <= rch + 1;
    initial begin
        repeat (98000) @(posedge pclk);
        err_total = err_total + 1;
        end_sim;
    end
    // main sequence
    initial begin
        seed = lfsr(seed);
        strap <= seed[2:0];
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(q & 32'h7, 32'h1);
        apb(1'b0, 12'h00c + {2'b00, seed, 2'b00}, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 12'h000, {seed, seed, seed, seed} | 32'h1);
        cmd(strap, 4'h3, est(0, 0, 0), 1'b1);
        wde <= 1'b1;
        repeat (10) @(posedge pclk);
        wde <= 1'b0;
        chk({31'h0, switch_drive}, 32'h1);
        wdp <= 1'b0;
        seed = lfsr(seed);
        cmd(strap ^ (seed[2:0] | 3'h1), 4'h1, 3'h0, 1'b1);
        chk(rch, 1);
        for (i = 0; i < 9; i = i + 1) begin
            cmd(strap, (i == 0) ? 4'h0 : 4'h7 + i[3:0], est(1, 0, 0), 1'b1);
            chk(rch, 2 + i);
        end
        wde <= 1'b1;
        repeat (10) @(posedge pclk);
        wde <= 1'b0;
        chk({31'h0, switch_drive}, 32'h0);
        wdp <= 1'b1;
        cmd(strap, 4'h6, est(0, 0, 0), 1'b0);
        zc;
        chk({31'h0, switch_drive}, 32'h1);
        svl <= 1'b1;
        repeat (300) @(posedge pclk);
        watch;
        chk(n_lo, 20);
        svl <= 1'b0;
        cmd(strap, 4'h2, est(1, 1, 0), 1'b1);
        iwin <= 1'b1;
        repeat (8) @(posedge pclk);
        iwin <= 1'b0;
        chk({31'h0, switch_drive}, 32'h0);
        cmd(strap, 4'h5, est(0, 0, 0), 1'b1);
        cmd(strap, 4'h1, est(1, 1, 0), 1'b0);
        cmd(strap, 4'h4, est(0, 0, 0), 1'b0);
        zc;
        chk({31'h0, switch_drive}, 32'h1);
        oc <= 1'b1;
        repeat (10) @(posedge pclk);
        oc <= 1'b0;
        cmd(strap, 4'h7, est(0, 0, 1), 1'b0);
        vsw <= ~vsw;
        watch;
        chk(n_hi, 20);
        end_sim;
    end
endmodule
